// >>> rtl/heatseal_control_sequencer.sv
// file: menu, heating target, calibration and hold sequencing
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - alarm shows fault step; reset goes home
// - short menu press jumps to trim
// - old units always list fault step
// - seal point must exceed 40 to heat
// - home shows live temperature when hold is off
// - analog linear, full scale at range
// - alarm: new error level, old last value
// - enter starts trim; ambient 0..40
// - ambient reference resets to 20
// - trim unheated, label blinks, analog low
// - new units retry trim twice
// - fast cooling locks trim
// - start input locks trim
// - error codes lock trim, some by history
// - start heats to seal point
// - manual key heats like start, at home or in manual step
// - heating led until seal temp reached
// - trim alarm plus start: relay, no heat
// - start plus warm-up heats warm-up point
// - warm-up point must exceed 40 to heat
// - manual key with warm-up heats warm-up
// - hold on shows end-of-phase value
// - brief hold shows latched value briefly
// - analog live temperature regardless of hold
module heatseal_control_sequencer #(
  parameter int unsigned MENU_SHORT_CYC = seq_pkg::MENU_SHORT_CYC, // short press limit
  parameter int unsigned FREEZE_BRIEF_CYC = seq_pkg::FREEZE_BRIEF_CYC, // brief hold time
  parameter int unsigned TRIM_RUN_CYC = seq_pkg::TRIM_RUN_CYC, // one trim pass
  parameter int unsigned DAC_W = 12 // analog output code width
) (
  input wire logic clk, // 10 MHz system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic newer_unit, // newer behaviour
  input wire logic manual_in_step, // manual key in manual_step
  input wire logic range_high, // 500 C range
  input wire logic start_in, // machine start input
  input wire logic warmup_in, // machine warm-up input
  input wire logic key_menu, // menu key level
  input wire logic key_enter, // enter key pulse
  input wire logic key_up, // up key pulse
  input wire logic key_down, // down key pulse
  input wire logic key_reset, // reset key pulse
  input wire logic key_manual, // manual heat key pulse
  input wire logic [9:0] actual_temp, // band temperature, C
  input wire logic [9:0] seal_setpoint, // heatsealing set point, C
  input wire logic [9:0] warmup_setpoint, // warm-up set point, C
  input wire logic [1:0] freeze_mode, // freeze_display_step setting
  input wire logic alarm_active, // an alarm is present
  input wire logic [9:0] alarm_code, // active error code
  input wire logic alarm_ackable, // fault clears by reset key
  input wire logic [DAC_W-1:0] alarm_dac_level, // error level for analog output
  input wire logic cooling_fast, // band cools faster than 0.1 K/s
  input wire logic trim_stable, // band steady during trim pass
  input wire logic phase_ok, // a correct operation completed
  output logic [4:0] menu_pos, // current menu step, one-hot
  output logic [9:0] display_value, // value or code on display
  output logic label_blink, // calibration label blinking
  output logic heat_enable, // regulate band
  output logic [9:0] heat_target, // set point in use
  output logic heating_led, // heating to seal point, not yet reached
  output logic warmup_led, // warm-up target in use
  output logic alarm_relay, // alarm relay
  output logic trim_busy, // zero_point_trim running
  output logic trim_fail, // pulse: trim failed after retries
  output logic fault_ack, // pulse: reset key acknowledged fault
  output logic [9:0] trim_ambient, // ambient reference, C
  output logic [DAC_W-1:0] analog_out // analog actual value code
);
  // ----------------------------------------
  // local declarations
  // ----------------------------------------
  localparam logic [DAC_W-1:0] DAC_FULL = {DAC_W{1'b1}}; // 10 V code
  seq_pkg::menu_t menu_q; // menu position
  logic [31:0] press_q; // menu key hold count
  logic menu_prev_q; // menu key last cycle
  logic menu_release, short_press; // menu key released, short
  logic ok_once_q; // correct operation seen since power-up
  logic start_prev_q; // start last cycle
  logic manual_hold_q; // manual heat active
  logic heating_q, heating_prev_q, phase_end; // heating phase, its end
  logic [9:0] latched_q; // end-of-phase temperature
  logic latched_valid_q; // latch filled once
  logic [1:0] tries_q; // trim passes done
  logic trim_block, trim_lock, trim_go, trim_kick; // trim refusal and starts
  logic pass_done; // trim pass expired
  logic brief_go; // brief hold timer start
  logic brief_busy; // brief hold window open
  logic blink_q; // blink phase
  logic [21:0] blink_cnt_q; // blink divider
  logic fault_code_trim; // trim-type alarm
  logic seal_ok, warm_ok; // set points heatable
  logic [9:0] target; // chosen target
  logic target_ok; // chosen target heatable
  logic [9:0] range_max; // range maximum in C
  logic [DAC_W+9:0] scaled; // temperature times full scale
  // ----------------------------------------
  // timers
  // ----------------------------------------
  ms_timer #(.CYCLES(TRIM_RUN_CYC)) u_trim_tmr (.clk(clk), .sys_rst(sys_rst),
    .start(trim_kick), .stop(1'b0), .busy(), .done(pass_done));
  ms_timer #(.CYCLES(FREEZE_BRIEF_CYC)) u_brief_tmr (.clk(clk), .sys_rst(sys_rst),
    .start(brief_go), .stop(1'b0), .busy(brief_busy), .done());
  // ----------------------------------------
  // combinational decisions
  // ----------------------------------------
  // short menu press
  assign menu_release = menu_prev_q && !key_menu;
  assign short_press = menu_release && (press_q < 32'(MENU_SHORT_CYC));
  // set points must exceed 40 C
  assign seal_ok = seal_setpoint > seq_pkg::SETPOINT_MIN_HEAT;
  assign warm_ok = warmup_setpoint > seq_pkg::SETPOINT_MIN_HEAT;
  // warm-up picks its target
  assign target = warmup_in ? warmup_setpoint : seal_setpoint;
  assign target_ok = warmup_in ? warm_ok : seal_ok;
  // trim-type alarms
  assign fault_code_trim = alarm_active && ((alarm_code >= 10'd104 && alarm_code <= 10'd105) ||
    (alarm_code >= 10'd111 && alarm_code <= 10'd113) || alarm_code == 10'd211);
  // some blocking codes depend on history
  always_comb begin
    trim_block = 1'b0;
    if (alarm_active) begin
      if ((alarm_code >= 10'd201 && alarm_code <= 10'd203) || alarm_code == 10'd801 ||
          (alarm_code >= 10'd900 && alarm_code <= 10'd999)) begin
        trim_block = 1'b1;
      end else if (!ok_once_q && alarm_code >= 10'd101 && alarm_code <= 10'd103) begin
        trim_block = 1'b1;
      end
    end
  end
  assign trim_lock = cooling_fast || start_in || trim_block;
  assign trim_go = (menu_q == seq_pkg::MENU_TRIM) && key_enter && !trim_lock;
  // enter starts, unstable band retries
  assign trim_kick = trim_go ||
    (pass_done && !trim_stable && newer_unit && tries_q < seq_pkg::TRIM_TRIES);
  assign phase_end = heating_prev_q && !heating_q;
  assign brief_go = phase_end && freeze_mode == seq_pkg::FREEZE_BRIEF;
  assign range_max = range_high ? seq_pkg::RANGE_HIGH_MAX : seq_pkg::RANGE_LOW_MAX;
  assign scaled = (DAC_W + 10)'(actual_temp) * (DAC_W + 10)'(DAC_FULL);

  // ----------------------------------------
  // menu navigation
  // ----------------------------------------
  // menu position
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      menu_q <= seq_pkg::MENU_HOME;
      fault_ack <= 1'b0;
    end else begin
      fault_ack <= 1'b0;
      unique case (menu_q)
        seq_pkg::MENU_HOME: begin
          if (alarm_active) begin
            menu_q <= seq_pkg::MENU_FAULT;
          end else if (short_press) begin
            // old units list fault step without alarm
            menu_q <= newer_unit ? seq_pkg::MENU_TRIM : seq_pkg::MENU_FAULT;
          end
        end
        seq_pkg::MENU_FAULT: begin
          if (key_reset && alarm_active && alarm_ackable) begin
            menu_q <= seq_pkg::MENU_HOME;
            fault_ack <= 1'b1;
          end else if (short_press) begin
            menu_q <= seq_pkg::MENU_TRIM;
          end else if (!alarm_active && newer_unit) begin
            menu_q <= seq_pkg::MENU_HOME;
          end
        end
        seq_pkg::MENU_TRIM: begin
          if (trim_go) begin
            menu_q <= seq_pkg::MENU_TRIM_RUN;
          end else if (short_press) begin
            menu_q <= manual_in_step ? seq_pkg::MENU_MANUAL : seq_pkg::MENU_HOME;
          end
        end
        seq_pkg::MENU_MANUAL: menu_q <= short_press ? seq_pkg::MENU_HOME : menu_q;
        seq_pkg::MENU_TRIM_RUN: menu_q <= trim_busy ? menu_q : seq_pkg::MENU_HOME;
        default: menu_q <= seq_pkg::MENU_HOME;
      endcase
    end
  end

  // menu key press length
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      press_q <= 32'h0;
      menu_prev_q <= 1'b0;
    end else begin
      menu_prev_q <= key_menu;
      if (!key_menu) begin
        press_q <= 32'h0;
      end else if (press_q != 32'hffffffff) begin
        press_q <= press_q + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // zero-point trim
  // ----------------------------------------
  // ambient reference and pass control
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trim_ambient <= seq_pkg::TRIM_AMB_RESET;
      trim_busy <= 1'b0;
      trim_fail <= 1'b0;
      tries_q <= 2'h0;
    end else begin
      trim_fail <= 1'b0;
      if (menu_q == seq_pkg::MENU_TRIM && newer_unit) begin
        if (key_up && trim_ambient < seq_pkg::TRIM_AMB_MAX) begin
          trim_ambient <= trim_ambient + 10'h001;
        end else if (key_down && trim_ambient != 10'h000) begin
          trim_ambient <= trim_ambient - 10'h001;
        end
      end
      if (trim_go && !newer_unit) begin
        trim_ambient <= seq_pkg::TRIM_AMB_RESET;
      end
      if (trim_kick) begin
        trim_busy <= 1'b1;
        tries_q <= trim_go ? 2'h1 : tries_q + 2'h1;
      end else if (pass_done) begin
        trim_busy <= 1'b0;
        trim_fail <= !trim_stable;
      end
    end
  end

  // correct operation seen
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ok_once_q <= 1'b0;
    end else if (phase_ok) begin
      ok_once_q <= 1'b1;
    end
  end

  // blink divider, phase toggles every 2^22 cycles (about 0.42 s)
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blink_cnt_q <= 22'h0;
      blink_q <= 1'b0;
      label_blink <= 1'b0;
    end else begin
      blink_cnt_q <= blink_cnt_q + 22'h1;
      if (blink_cnt_q == 22'h0) begin
        blink_q <= !blink_q;
      end
      label_blink <= trim_busy && blink_q;
    end
  end

  // ----------------------------------------
  // heating control
  // ----------------------------------------
  // start and manual key request heating, warm-up picks the target
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_prev_q <= 1'b0;
      manual_hold_q <= 1'b0;
      heating_q <= 1'b0;
      heating_prev_q <= 1'b0;
      heat_enable <= 1'b0;
      heat_target <= 10'h000;
      heating_led <= 1'b0;
      warmup_led <= 1'b0;
      alarm_relay <= 1'b0;
    end else begin
      start_prev_q <= start_in;
      heating_prev_q <= heating_q;
      // manual key at home, or in manual step
      if (key_manual && !start_in &&
          ((menu_q == seq_pkg::MENU_HOME && !manual_in_step) ||
           (menu_q == seq_pkg::MENU_MANUAL && manual_in_step))) begin
        manual_hold_q <= !manual_hold_q;
      end else if (start_in && !start_prev_q) begin
        manual_hold_q <= 1'b0;
      end
      alarm_relay <= start_in && fault_code_trim;
      heating_q <= (start_in || manual_hold_q) && target_ok && !fault_code_trim &&
        !trim_busy && !alarm_active;
      heat_enable <= heating_q;
      heat_target <= target;
      heating_led <= heating_q && !warmup_in && actual_temp < seal_setpoint;
      warmup_led <= heating_q && warmup_in;
    end
  end

  // ----------------------------------------
  // display and analog output
  // ----------------------------------------
  // end-of-phase latch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latched_q <= 10'h000;
      latched_valid_q <= 1'b0;
    end else if (phase_end) begin
      latched_q <= actual_temp;
      latched_valid_q <= 1'b1;
    end
  end

  // display selection per menu step
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      display_value <= 10'h000;
      menu_pos <= seq_pkg::MENU_HOME;
    end else begin
      menu_pos <= menu_q;
      unique case (menu_q)
        seq_pkg::MENU_HOME: begin
          if (freeze_mode == seq_pkg::FREEZE_ON && latched_valid_q) begin
            display_value <= latched_q;
          end else if (freeze_mode == seq_pkg::FREEZE_BRIEF && brief_busy) begin
            display_value <= latched_q;
          end else begin
            display_value <= actual_temp;
          end
        end
        seq_pkg::MENU_FAULT:
          display_value <= alarm_active ? alarm_code : seq_pkg::DISP_NO_FAULT;
        seq_pkg::MENU_TRIM: begin
          if (!newer_unit && (cooling_fast || start_in)) begin
            display_value <= seq_pkg::DISP_LOCK_PLAIN;
          end else if (cooling_fast) begin
            display_value <= seq_pkg::DISP_COOL_LOCK;
          end else if (start_in) begin
            display_value <= seq_pkg::DISP_START_LOCK;
          end else begin
            display_value <= trim_ambient;
          end
        end
        seq_pkg::MENU_MANUAL: display_value <= actual_temp;
        seq_pkg::MENU_TRIM_RUN: display_value <= trim_fail ? seq_pkg::TRIM_FAIL_CODE : trim_ambient;
        default: display_value <= actual_temp;
      endcase
    end
  end

  // analog actual value, live regardless of hold
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      analog_out <= '0;
    end else if (trim_busy) begin
      analog_out <= '0;
    end else if (alarm_active) begin
      analog_out <= newer_unit ? alarm_dac_level : analog_out;
    end else if (actual_temp >= range_max) begin
      analog_out <= DAC_FULL;
    end else begin
      analog_out <= DAC_W'(scaled / (DAC_W + 10)'(range_max));
    end
  end
endmodule
`default_nettype wire

// >>> rtl/seq_pkg.sv
// package: sequencer constants
package seq_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000; // system clock rate
  localparam int unsigned MENU_SHORT_MS = 2000; // brief menu press limit
  localparam int unsigned MENU_SHORT_CYC = MENU_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned FREEZE_BRIEF_MS = 2000; // brief hold duration
  localparam int unsigned FREEZE_BRIEF_CYC = FREEZE_BRIEF_MS * (CLK_HZ / 1000);
  localparam int unsigned TRIM_RUN_MS = 12000; // one calibration pass, 10..15 s
  localparam int unsigned TRIM_RUN_CYC = TRIM_RUN_MS * (CLK_HZ / 1000);
  // ----------------------------------------
  // temperature limits
  // ----------------------------------------
  localparam logic [9:0] SETPOINT_MIN_HEAT = 10'h028; // 40 C, must exceed
  localparam logic [9:0] TRIM_AMB_MAX = 10'h028; // 40 C ambient upper bound
  localparam logic [9:0] TRIM_AMB_RESET = 10'h014; // 20 C factory default
  localparam logic [9:0] RANGE_LOW_MAX = 10'h12c; // 300 C range
  localparam logic [9:0] RANGE_HIGH_MAX = 10'h1f4; // 500 C range
  localparam logic [1:0] TRIM_TRIES = 2'h3; // passes before failure
  // ----------------------------------------
  // display codes
  // ----------------------------------------
  localparam logic [9:0] DISP_NO_FAULT = 10'h000; // older fault step idle
  localparam logic [9:0] DISP_LOCK_PLAIN = 10'h3f0; // plain lock message
  localparam logic [9:0] DISP_COOL_LOCK = 10'h3f1; // cooling_lock_msg
  localparam logic [9:0] DISP_START_LOCK = 10'h3f2; // start_lock_msg
  localparam logic [9:0] TRIM_FAIL_CODE = 10'h1f7; // error after failed passes (503)
  // ----------------------------------------
  // hold settings
  // ----------------------------------------
  localparam logic [1:0] FREEZE_OFF = 2'h0;
  localparam logic [1:0] FREEZE_ON = 2'h1;
  localparam logic [1:0] FREEZE_BRIEF = 2'h2; // brief_freeze_setting
  // ----------------------------------------
  // menu position (one-hot)
  // ----------------------------------------
  typedef enum logic [4:0] {
    MENU_HOME = 5'h01,
    MENU_FAULT = 5'h02,
    MENU_TRIM = 5'h04,
    MENU_MANUAL = 5'h08,
    MENU_TRIM_RUN = 5'h10
  } menu_t;
endpackage

// >>> rtl/ms_timer.sv
// file: cycle countdown timer with done pulse
`timescale 1ns/1ps
`default_nettype none
module ms_timer #(
  parameter int unsigned CYCLES = 20000000 // cycles to count
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic start, // (re)load and run
  input wire logic stop, // abort counting
  output logic busy, // counting in progress
  output logic done // one-cycle pulse at expiry
);
  logic [31:0] cnt_q; // remaining cycles

  // count down from load value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 32'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (stop) begin
        busy <= 1'b0;
      end else if (start) begin
        cnt_q <= 32'(CYCLES - 1);
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt_q == 32'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 32'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/seq_asserts.sv
// checker: temporal properties at the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module seq_asserts #(
  parameter int unsigned DAC_W = 12 // analog code width
) (
  input wire logic clk, // clock
  input wire logic sys_rst, // sync reset
  input wire logic newer_unit, // generation
  input wire logic range_high, // 500 c range
  input wire logic start_in, // start
  input wire logic warmup_in, // warm-up
  input wire logic [9:0] actual_temp, // live temp
  input wire logic [9:0] seal_setpoint, // seal point
  input wire logic [9:0] warmup_setpoint, // warm-up point
  input wire logic alarm_active, // alarm
  input wire logic [9:0] alarm_code, // error code
  input wire logic [DAC_W-1:0] alarm_dac_level, // error level
  input wire logic heat_enable, // heating
  input wire logic [9:0] heat_target, // target
  input wire logic warmup_led, // warm-up led
  input wire logic alarm_relay, // relay
  input wire logic trim_busy, // trim running
  input wire logic [9:0] trim_ambient, // ambient ref
  input wire logic [DAC_W-1:0] analog_out // analog code
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic trim_code; // alarm a trim can clear
  logic [21:0] scaled; // ideal analog code
  // alarm class, ideal analog code
  always_comb begin
    trim_code = alarm_code inside {10'h068, 10'h069, [10'h06f:10'h071], 10'h0d3};
    scaled = 22'(actual_temp) * 22'((1 << DAC_W) - 1) / (range_high ? 22'h1f4 : 22'h12c);
  end
  // quiet: no alarm or trim, steady temperature
  sequence s_quiet;
    (!alarm_active && !trim_busy && actual_temp <= (range_high ? 10'h1f4 : 10'h12c)
      && $stable(actual_temp) && $stable(range_high)) [*3];
  endsequence
  // start without warm-up, points valid
  sequence s_seal_req;
    (start_in && !warmup_in && !alarm_active && !trim_busy && seal_setpoint > 10'h028
      && warmup_setpoint > 10'h028 && $stable(seal_setpoint)) [*3];
  endsequence
  a_trim_no_heat: assert property (trim_busy [*2] |-> !heat_enable)
    else $error("band heated during trim");
  a_heat_floor: assert property ($rose(heat_enable) |-> heat_target > 10'h028)
    else $error("heating with target not above 40");
  a_seal_target: assert property (s_seal_req |-> heat_enable && heat_target == seal_setpoint)
    else $error("seal point not regulated");
  a_warmup_target: assert property ((start_in && warmup_in && !alarm_active && !trim_busy
    && seal_setpoint > 10'h028 && warmup_setpoint > 10'h028) [*3] |-> heat_enable
    && heat_target == warmup_setpoint && warmup_led) else $error("warm-up point not used");
  a_relay_on_start: assert property (alarm_active && trim_code && start_in |-> ##[1:2] alarm_relay)
    else $error("relay not switched");
  a_trim_analog_low: assert property (trim_busy [*2] |-> (analog_out >> (DAC_W - 6)) == '0)
    else $error("analog not near zero during trim");
  a_analog_live: assert property (s_quiet |-> 22'(analog_out) + 22'h1 >= scaled
    && 22'(analog_out) <= scaled + 22'h1) else $error("analog not linear in temperature");
  a_alarm_level: assert property ((newer_unit && alarm_active && !trim_code && !trim_busy
    && $stable(alarm_dac_level)) [*3] |-> analog_out == alarm_dac_level)
    else $error("alarm level missing on analog");
  a_old_hold: assert property ((!newer_unit && alarm_active) [*3] |-> $stable(analog_out))
    else $error("old unit analog moved in alarm");
  a_ambient_reset: assert property ($fell(sys_rst) |-> trim_ambient == 10'h014)
    else $error("ambient reference not 20");
endmodule
bind heatseal_control_sequencer seq_asserts #(.DAC_W(DAC_W)) chk (.clk, .sys_rst,
  .newer_unit, .range_high, .start_in, .warmup_in, .actual_temp, .seal_setpoint,
  .warmup_setpoint, .alarm_active, .alarm_code, .alarm_dac_level, .heat_enable,
  .heat_target, .warmup_led, .alarm_relay, .trim_busy, .trim_ambient, .analog_out);
`default_nettype wire

// >>> tb/panel_model.sv
// model: keypad turning requests into keys
`timescale 1ns/1ps
`default_nettype none
module panel_model #(
  parameter int unsigned MENU_LEN = 5 // menu hold, a brief press
) (
  input wire logic clk, // clock
  input wire logic press, // one-cycle request
  input wire logic [2:0] key_sel, // 0 menu 1 enter 2 up 3 down 4 reset 5 manual
  output logic [5:0] keys // manual reset down up enter menu
);
  int unsigned held_q = 0; // menu hold countdown
  // hold menu key well under the long-press limit
  always_ff @(posedge clk) begin
    if (press && key_sel == 3'h0) begin
      held_q <= MENU_LEN;
    end else if (held_q != 0) begin
      held_q <= held_q - 1;
    end
  end
  assign keys[0] = held_q != 0;
  // other keys are single-cycle pulses
  assign keys[5:1] = press ? 5'((6'h01 << key_sel) >> 1) : 5'h00;
endmodule
`default_nettype wire

// >>> tb/heatseal_control_sequencer_tb.sv
// bench: sequencer directed and random checks
`timescale 1ns/1ps
`default_nettype none
module heatseal_control_sequencer_tb;
  typedef struct {int sel; logic [11:0] exp;} note_t;
  logic clk = 0, sys_rst, newer_unit, manual_in_step, range_high, start_in, warmup_in, press;
  logic alarm_active, alarm_ackable, cooling_fast, trim_stable, phase_ok, label_blink;
  logic heat_enable, heating_led, warmup_led, alarm_relay, trim_busy, trim_fail, fault_ack;
  logic [9:0] actual_temp, seal_setpoint, warmup_setpoint, alarm_code, sp;
  logic [9:0] display_value, heat_target, trim_ambient; // displayed values
  logic [11:0] alarm_dac_level, analog_out, lvl; // analog codes
  logic [5:0] keys; // keypad lines
  logic [4:0] menu_pos; // menu step
  logic [2:0] key_sel; // requested key
  logic [1:0] freeze_mode; // hold setting
  note_t notes[$]; // expected results
  note_t nt; // note under comparison
  int n_mismatch = 0, checked = 0, seed = 5;
  logic [9:0] codes [6] = '{10'h068, 10'h069, 10'h06f, 10'h070, 10'h071, 10'h0d3};
  string names [10] = '{"heat_enable", "heat_target", "heating_led", "warmup_led",
    "alarm_relay", "menu_pos", "display_value", "trim_ambient", "analog_out", "trim_busy"};
  always #50 clk = ~clk;
  panel_model pnl (.clk, .press, .key_sel, .keys);
  heatseal_control_sequencer #(.MENU_SHORT_CYC(20), .FREEZE_BRIEF_CYC(20), .TRIM_RUN_CYC(20))
    uut (.clk, .sys_rst, .newer_unit, .manual_in_step, .range_high, .start_in, .warmup_in,
    .key_menu(keys[0]), .key_enter(keys[1]), .key_up(keys[2]), .key_down(keys[3]),
    .key_reset(keys[4]), .key_manual(keys[5]), .actual_temp, .seal_setpoint, .warmup_setpoint,
    .freeze_mode, .alarm_active, .alarm_code, .alarm_ackable, .alarm_dac_level, .cooling_fast,
    .trim_stable, .phase_ok, .menu_pos, .display_value, .label_blink, .heat_enable, .heat_target,
    .heating_led, .warmup_led, .alarm_relay, .trim_busy, .trim_fail, .fault_ack, .trim_ambient,
    .analog_out);
  logic [11:0] ov [10]; // observed outputs by note index
  assign ov = '{12'(heat_enable), 12'(heat_target), 12'(heating_led), 12'(warmup_led),
    12'(alarm_relay), 12'(menu_pos), 12'(display_value), 12'(trim_ambient), analog_out,
    12'(trim_busy)};
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic key(input logic [2:0] s);
    press <= 1'b1;
    key_sel <= s;
    @(posedge clk);
    press <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input int s, input logic [11:0] e);
    notes.push_back('{s, e});
  endtask
  task automatic cmp_val(input string nm, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // monitor: compare notes on settled outputs
  always @(negedge clk) begin
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      cmp_val(names[nt.sel], nt.exp, ov[nt.sel]);
    end
  end
  // watchdog: tests need under 1000 cycles
  initial begin
    step(3000);
    n_mismatch++;
    finish_test;
  end
  initial begin
    {sys_rst, newer_unit, manual_in_step, range_high, start_in, warmup_in, press} = 7'h60;
    {alarm_active, alarm_ackable, cooling_fast, trim_stable, phase_ok} = 5'h00;
    {key_sel, freeze_mode, alarm_code, alarm_dac_level} = '0;
    {actual_temp, seal_setpoint, warmup_setpoint} = {10'h014, 10'h096, 10'h064};
    step(10);
    sys_rst <= 1'b0;
    step(1);
    chk(5, 12'h001);
    chk(7, 12'h014);
    sp = 10'h029 + 10'($unsigned($random(seed)) % 200);
    seal_setpoint <= sp;
    start_in <= 1'b1;
    step(4);
    chk(1, 12'(sp));
    chk(2, 12'h001);
    actual_temp <= 10'h12c;
    step(4);
    chk(2, 12'h000);
    chk(8, 12'hfff);
    chk(6, 12'h12c);
    warmup_in <= 1'b1;
    step(4);
    chk(1, 12'h064);
    chk(3, 12'h001);
    {start_in, warmup_in} <= 2'h0;
    step(4);
    seal_setpoint <= 10'h028;
    start_in <= 1'b1;
    step(4);
    chk(0, 12'h000);
    {start_in, seal_setpoint, warmup_setpoint, warmup_in} <= {1'b0, 10'h096, 10'h028, 1'b1};
    step(2);
    start_in <= 1'b1;
    step(4);
    chk(0, 12'h000);
    {start_in, warmup_in, warmup_setpoint} <= {2'h0, 10'h064};
    step(4);
    $display("test set points done");
    key(3'h5);
    step(2);
    chk(0, 12'h001);
    key(3'h5);
    warmup_in <= 1'b1;
    step(2);
    key(3'h5);
    step(2);
    chk(1, 12'h064);
    chk(3, 12'h001);
    key(3'h5);
    warmup_in <= 1'b0;
    step(3);
    chk(0, 12'h000);
    $display("test manual heat done");
    foreach (codes[i]) begin
      {alarm_code, alarm_active, start_in} <= {codes[i], 2'h3};
      step(3);
      chk(4, 12'h001);
      chk(0, 12'h000);
      {alarm_active, start_in} <= 2'h0;
      step(3);
    end
    lvl = 12'($random(seed));
    {actual_temp, alarm_dac_level, alarm_code} <= {10'h03c, lvl, 10'h133};
    {alarm_ackable, alarm_active} <= 2'h3;
    step(4);
    chk(8, lvl);
    chk(5, 12'h002);
    {press, key_sel} <= {1'b1, 3'h4};
    step(1);
    {press, alarm_active, alarm_ackable} <= 3'h0;
    step(3);
    chk(5, 12'h001);
    newer_unit <= 1'b0;
    step(3);
    alarm_active <= 1'b1;
    step(2);
    actual_temp <= 10'h12c;
    step(3);
    chk(8, 12'h333);
    {alarm_active, newer_unit} <= 2'h1;
    step(3);
    chk(8, 12'hfff);
    $display("test alarms done");
    for (int m = 1; m < 3; m++) begin
      {freeze_mode, actual_temp, start_in} <= {2'(m), 10'h078 + 10'(m), 1'b1};
      step(4);
      start_in <= 1'b0;
      step(3);
      actual_temp <= 10'h03c;
      step(3);
      chk(6, 12'h078 + 12'(m));
      chk(8, 12'h333);
      step(24);
      chk(6, (m == 2) ? 12'h03c : 12'h079);
    end
    freeze_mode <= 2'h0;
    $display("test hold done");
    {alarm_code, alarm_active} <= {10'h068, 1'b1};
    step(3);
    key(3'h0);
    step(8);
    chk(5, 12'h004);
    key(3'h2);
    key(3'h2);
    step(2);
    chk(7, 12'h016);
    cooling_fast <= 1'b1;
    key(3'h1);
    step(2);
    chk(9, 12'h000);
    chk(6, 12'h3f1);
    {cooling_fast, start_in} <= 2'h1;
    key(3'h1);
    step(2);
    chk(9, 12'h000);
    chk(6, 12'h3f2);
    {start_in, actual_temp} <= {1'b0, 10'h0c8};
    step(2);
    key(3'h1);
    step(2);
    chk(9, 12'h001);
    step(43);
    chk(9, 12'h001);
    step(40);
    chk(9, 12'h000);
    alarm_active <= 1'b0;
    step(2);
    $display("test trim done");
    finish_test;
  end
endmodule
`default_nettype wire
